// [uwbe_pkg.sv]
package uwbe_pkg;
	// payload rates; the code doubles as the header rate field
	typedef enum logic [1:0] {
		RATE_110K,
		RATE_850K,
		RATE_6M8,
		RATE_27M
	} uwbe_rate_type;
	// chip timing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SYNC,
		ST_SFD,
		ST_SYM,
		ST_END
	} uwbe_state_type;
	// bit source phases
	typedef enum logic [2:0] {
		SRC_IDLE,
		SRC_HDR,
		SRC_INFO,
		SRC_PAR,
		SRC_TAIL,
		SRC_DONE
	} uwbe_src_type;
	// header layout
	localparam logic [4:0] HDR_LAST = 5'h12;
	localparam logic [4:0] HDR_COUNT = 5'h13;
	localparam logic [12:0] CHK_MASK [5] = '{13'h0b5b, 13'h066d, 13'h1c8e,
		13'h1f0f, 13'h1ff0};
	localparam logic TAIL_LAST = 1'b1;
	// chips per symbol and per burst for each rate
	localparam logic [12:0] NC_110K = 13'h1000;
	localparam logic [12:0] NC_850K = 13'h0200;
	localparam logic [12:0] NC_6M8 = 13'h0040;
	localparam logic [12:0] NC_27M = 13'h0020;
	localparam logic [7:0] NB_110K = 8'h80;
	localparam logic [7:0] NB_850K = 8'h10;
	localparam logic [7:0] NB_6M8 = 8'h02;
	localparam logic [7:0] NB_27M = 8'h01;
	// preamble: 31 code chips, spread 16 (1.01 Msym/s) or 64 (0.25 Msym/s)
	localparam logic [4:0] CODE_LAST = 5'h1e;
	localparam logic [6:0] SPREAD_FAST_LAST = 7'h0f;
	localparam logic [6:0] SPREAD_SLOW_LAST = 7'h3f;
	localparam logic [4:0] SYNC_LAST = 5'h0f;
	localparam logic [4:0] SFD_LAST = 5'h07;
	localparam logic [7:0] SFD_ON = 8'hb7;
	localparam logic [7:0] SFD_NEG = 8'h25;
	// reed-solomon over gf(64), 55 info symbols then 8 parity symbols
	localparam logic [8:0] RS_BLK_LAST = 9'h149;
	localparam logic [2:0] RS_SYM_LAST = 3'h5;
	localparam logic [2:0] RS_PAR_LAST = 3'h7;
	localparam logic [5:0] GF_POLY = 6'h03;
	localparam logic [5:0] RS_GEN [8] = '{6'h18, 6'h2d, 6'h07, 6'h3a,
		6'h11, 6'h26, 6'h0c, 6'h35};
	localparam int PAY_DEPTH = 128;

	// multiply in gf(64)
	function automatic logic [5:0] gf_mul(input logic [5:0] a,
		input logic [5:0] b);
		logic [5:0] p;
		logic [5:0] x;
		p = 6'h00;
		x = a;
		for (int i = 0; i < 6; i++) begin
			if (b[i]) p = p ^ x;
			x = x[5] ? ({x[4:0], 1'b0} ^ GF_POLY) : {x[4:0], 1'b0};
		end
		return p;
	endfunction

	// chips in one symbol at a rate
	function automatic logic [12:0] nc_of(input uwbe_rate_type r);
		unique case (r)
			RATE_110K: return NC_110K;
			RATE_850K: return NC_850K;
			RATE_6M8: return NC_6M8;
			RATE_27M: return NC_27M;
		endcase
	endfunction

	// chips in one burst at a rate
	function automatic logic [7:0] nb_of(input uwbe_rate_type r);
		unique case (r)
			RATE_110K: return NB_110K;
			RATE_850K: return NB_850K;
			RATE_6M8: return NB_6M8;
			RATE_27M: return NB_27M;
		endcase
	endfunction
endpackage

// [uwbe_conv_if.sv]
interface uwbe_conv_if;
	logic clr;
	logic load;
	logic two;
	logic b0;
	logic b1;
	logic pos;
	logic pol;
	modport enc (output clr, load, two, b0, b1, input pos, pol);
	modport cv (input clr, load, two, b0, b1, output pos, pol);
endinterface

// [uwbe_conv.sv]
module uwbe_conv (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bits in, position and polarity out
	uwbe_conv_if.cv cif
);
	logic d1_r;
	logic d2_r;
	logic pos_r;
	logic pol_r;
	logic first_r;
	logic prev_r;
	logic prev2_r;

	// rate one-half coder with two-stage delay line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			d1_r <= 1'b0;
			d2_r <= 1'b0;
			pos_r <= 1'b0;
			pol_r <= 1'b0;
		end else if (cif.clr) begin
			d1_r <= 1'b0;
			d2_r <= 1'b0;
			pos_r <= 1'b0;
			pol_r <= 1'b0;
		end else if (cif.load && cif.two) begin
			pos_r <= cif.b0;
			pol_r <= cif.b1;
			d1_r <= cif.b1;
			d2_r <= cif.b0;
		end else if (cif.load) begin
			pos_r <= d1_r;
			pol_r <= cif.b0 ^ d2_r;
			d1_r <= cif.b0;
			d2_r <= d1_r;
		end
	end

	assign cif.pos = pos_r;
	assign cif.pol = pol_r;

	// shadow of the input history for the checks below
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_r <= 1'b0;
			prev_r <= 1'b0;
			prev2_r <= 1'b0;
		end else if (cif.clr) begin
			first_r <= 1'b1;
			prev_r <= 1'b0;
			prev2_r <= 1'b0;
		end else if (cif.load) begin
			first_r <= 1'b0;
			prev_r <= cif.two ? cif.b1 : cif.b0;
			prev2_r <= cif.two ? cif.b0 : prev_r;
		end
	end

	a_first_pos: assert property (@(posedge clk) disable iff (rst)
		cif.load && first_r && !cif.two |=> !cif.pos)
		else $error("first symbol position not zero");
	a_pos_prev: assert property (@(posedge clk) disable iff (rst)
		cif.load && !cif.two |=> cif.pos == $past(prev_r))
		else $error("position bit is not the previous input");
	a_pol_xor: assert property (@(posedge clk) disable iff (rst)
		cif.load && !cif.two |=> cif.pol == ($past(cif.b0) ^ $past(prev2_r)))
		else $error("polarity bit is not current xor two back");
	a_two_bits: assert property (@(posedge clk) disable iff (rst)
		cif.load && cif.two |=> cif.pos == $past(cif.b0) && cif.pol == $past(cif.b1))
		else $error("bypassed symbol does not carry two bits");
	c_bypass: cover property (@(posedge clk) disable iff (rst)
		cif.load && cif.two);
endmodule // uwbe_conv

// [uwbe_encoder.sv]
module uwbe_encoder #(
	// ternary preamble codes, nonzero mask and sign mask (arbitrary values)
	parameter logic [30:0] CODE_A_ON = 31'h3bdef7bd,
	parameter logic [30:0] CODE_A_NEG = 31'h12345678,
	parameter logic [30:0] CODE_B_ON = 31'h6f7bdeef,
	parameter logic [30:0] CODE_B_NEG = 31'h0a5c3e21
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// frame request
	input wire logic start,
	input wire uwbe_pkg::uwbe_rate_type rate,
	input wire logic conv_bypass,
	input wire logic code_sel,
	input wire logic prf_slow,
	input wire logic ranging,
	input wire logic [1:0] pre_dur,
	input wire logic [6:0] pay_len,
	// payload store
	input wire logic pay_wr,
	input wire logic [6:0] pay_idx,
	input wire logic [7:0] pay_data,
	// chip stream
	output logic tx_busy,
	output logic chip_on,
	output logic chip_neg,
	// symbol stream
	output logic sym_start,
	output logic sym_pos,
	output logic sym_pol,
	output logic sym_hdr,
	output logic frame_done
);
	uwbe_conv_if cif ();

	logic [7:0] pay_mem_r [uwbe_pkg::PAY_DEPTH];
	uwbe_pkg::uwbe_rate_type rate_r;
	logic bypass_r;
	logic codesel_r;
	logic slow_r;
	logic [6:0] len_r;
	logic [18:0] hdr_r;
	uwbe_pkg::uwbe_src_type src_r;
	logic [4:0] hb_r;
	logic [6:0] byte_r;
	logic [2:0] bit_r;
	logic [5:0] acc_r;
	logic [2:0] accn_r;
	logic [8:0] blk_r;
	logic [47:0] par_r;
	logic [2:0] ps_r;
	logic [2:0] psym_r;
	logic tl_r;
	logic pdone_r;
	logic [1:0] q_r;
	logic [1:0] qt_r;
	logic [1:0] qn_r;
	uwbe_pkg::uwbe_state_type st_r;
	logic [12:0] c_r;
	logic [12:0] nc_r;
	logic [7:0] nb_r;
	logic [6:0] sp_r;
	logic [4:0] k_r;
	logic [4:0] ns_r;
	logic hdr_sym_r;
	logic tx_busy_r;
	logic chip_on_r;
	logic chip_neg_r;
	logic sym_start_r;
	logic sym_pos_r;
	logic sym_pol_r;
	logic sym_hdr_r;
	logic frame_done_r;
	logic [1:0] popped_r;
	logic sfd_seen_r;
	logic go;
	logic push;
	logic pop;
	logic pop2;
	logic src_bit;
	logic last_bit;
	logic sym_done;
	logic [5:0] sym_in;
	logic [5:0] rs_fb;
	logic [47:0] par_step;
	logic [5:0] par_top;
	logic [7:0] cur_byte;
	logic [6:0] spread_last;
	logic pre_end;
	logic sym_end;
	uwbe_pkg::uwbe_rate_type hdr_rate;
	uwbe_pkg::uwbe_rate_type sym_rate;
	logic [12:0] lo;
	logic sym_on;
	logic pre_on;
	logic pre_neg;

	// header word: fields lsb first, then six check bits
	function automatic logic [18:0] phr_word(input logic [12:0] f);
		logic [5:0] c;
		for (int i = 0; i < 5; i++) c[i] = ^(f & uwbe_pkg::CHK_MASK[i]);
		c[5] = ^{f, c[4:0]};
		return {c, f};
	endfunction

	assign go = start && st_r == uwbe_pkg::ST_IDLE;

	// payload store written by the mac
	always_ff @(posedge clk) begin
		if (pay_wr) pay_mem_r[pay_idx] <= pay_data;
	end

	// frame settings caught at start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_r <= uwbe_pkg::RATE_850K;
			bypass_r <= 1'b0;
			codesel_r <= 1'b0;
			slow_r <= 1'b0;
			len_r <= 7'h00;
			hdr_r <= 19'h00000;
		end else if (go) begin
			rate_r <= rate;
			bypass_r <= conv_bypass;
			codesel_r <= code_sel;
			slow_r <= prf_slow;
			len_r <= pay_len;
			hdr_r <= phr_word({pre_dur, 1'b0, ranging, pay_len, rate});
		end
	end

	// current source bit
	assign cur_byte = pay_mem_r[byte_r];
	assign par_top = par_r[47:42];
	always_comb begin
		src_bit = 1'b0;
		unique case (src_r)
			uwbe_pkg::SRC_HDR: src_bit = hdr_r[hb_r];
			uwbe_pkg::SRC_INFO: src_bit = cur_byte[bit_r];
			uwbe_pkg::SRC_PAR: src_bit = par_top[ps_r];
			default: src_bit = 1'b0;
		endcase
	end

	// reed-solomon symbol assembly and parity update
	assign last_bit = byte_r == len_r - 7'h01 && bit_r == 3'h7;
	assign sym_done = accn_r == uwbe_pkg::RS_SYM_LAST || last_bit;
	assign sym_in = acc_r | (6'(src_bit) << accn_r);
	assign rs_fb = sym_in ^ par_r[47:42];
	for (genvar i = 0; i < 8; i++) begin : g_rs
		if (i == 0) begin : g_first
			assign par_step[5:0] = uwbe_pkg::gf_mul(rs_fb, uwbe_pkg::RS_GEN[0]);
		end else begin : g_rest
			assign par_step[6*i+5:6*i] = par_r[6*i-1:6*i-6]
				^ uwbe_pkg::gf_mul(rs_fb, uwbe_pkg::RS_GEN[i]);
		end
	end

	// bit source: header, coded payload blocks, tail
	assign push = qn_r != 2'h2 && !pop && src_r != uwbe_pkg::SRC_IDLE
		&& src_r != uwbe_pkg::SRC_DONE;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_r <= uwbe_pkg::SRC_IDLE;
			hb_r <= 5'h00;
			byte_r <= 7'h00;
			bit_r <= 3'h0;
			acc_r <= 6'h00;
			accn_r <= 3'h0;
			blk_r <= 9'h000;
			par_r <= 48'h0;
			ps_r <= 3'h0;
			psym_r <= 3'h0;
			tl_r <= 1'b0;
			pdone_r <= 1'b0;
		end else if (go) begin
			src_r <= uwbe_pkg::SRC_HDR;
			hb_r <= 5'h00;
			byte_r <= 7'h00;
			bit_r <= 3'h0;
			acc_r <= 6'h00;
			accn_r <= 3'h0;
			blk_r <= 9'h000;
			par_r <= 48'h0;
			ps_r <= 3'h0;
			psym_r <= 3'h0;
			tl_r <= 1'b0;
			pdone_r <= 1'b0;
		end else if (push) begin
			unique case (src_r)
				uwbe_pkg::SRC_HDR: begin
					hb_r <= hb_r + 5'h01;
					if (hb_r == uwbe_pkg::HDR_LAST) begin
						src_r <= len_r == 7'h00 ? uwbe_pkg::SRC_TAIL
							: uwbe_pkg::SRC_INFO;
					end
				end
				uwbe_pkg::SRC_INFO: begin
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7) byte_r <= byte_r + 7'h01;
					blk_r <= blk_r + 9'h001;
					if (sym_done) begin
						acc_r <= 6'h00;
						accn_r <= 3'h0;
						par_r <= par_step;
					end else begin
						acc_r <= sym_in;
						accn_r <= accn_r + 3'h1;
					end
					if (last_bit || blk_r == uwbe_pkg::RS_BLK_LAST) begin
						src_r <= uwbe_pkg::SRC_PAR;
						pdone_r <= last_bit;
						blk_r <= 9'h000;
					end
				end
				uwbe_pkg::SRC_PAR: begin
					ps_r <= ps_r + 3'h1;
					if (ps_r == uwbe_pkg::RS_SYM_LAST) begin
						ps_r <= 3'h0;
						par_r <= {par_r[41:0], 6'h00};
						psym_r <= psym_r + 3'h1;
						if (psym_r == uwbe_pkg::RS_PAR_LAST) begin
							src_r <= pdone_r ? uwbe_pkg::SRC_TAIL
								: uwbe_pkg::SRC_INFO;
						end
					end
				end
				uwbe_pkg::SRC_TAIL: begin
					tl_r <= 1'b1;
					if (tl_r == uwbe_pkg::TAIL_LAST) src_r <= uwbe_pkg::SRC_DONE;
				end
				default: src_r <= uwbe_pkg::SRC_IDLE;
			endcase
		end
	end

	// two-bit queue between source and symbol timing, tagged header or not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= 2'h0;
			qt_r <= 2'h0;
			qn_r <= 2'h0;
		end else if (go) begin
			qn_r <= 2'h0;
		end else if (pop2) begin
			qn_r <= 2'h0;
		end else if (pop) begin
			q_r[0] <= q_r[1];
			qt_r[0] <= qt_r[1];
			qn_r <= qn_r - 2'h1;
		end else if (push) begin
			q_r[qn_r[0]] <= src_bit;
			qt_r[qn_r[0]] <= src_r == uwbe_pkg::SRC_HDR;
			qn_r <= qn_r + 2'h1;
		end
	end

	// symbol boundaries and the rate of the next symbol
	assign spread_last = slow_r ? uwbe_pkg::SPREAD_SLOW_LAST
		: uwbe_pkg::SPREAD_FAST_LAST;
	assign pre_end = sp_r == spread_last && k_r == uwbe_pkg::CODE_LAST;
	assign sym_end = (st_r == uwbe_pkg::ST_SFD && pre_end
		&& ns_r == uwbe_pkg::SFD_LAST)
		|| (st_r == uwbe_pkg::ST_SYM && c_r == nc_r - 13'h0001);
	assign pop = sym_end && qn_r != 2'h0;
	assign pop2 = pop && bypass_r && rate_r == uwbe_pkg::RATE_27M
		&& !qt_r[0] && qn_r == 2'h2;
	assign hdr_rate = rate_r == uwbe_pkg::RATE_110K ? uwbe_pkg::RATE_110K
		: uwbe_pkg::RATE_850K;
	assign sym_rate = qt_r[0] ? hdr_rate : rate_r;

	// coder hookup
	assign cif.clr = go;
	assign cif.load = pop;
	assign cif.two = pop2;
	assign cif.b0 = q_r[0];
	assign cif.b1 = q_r[1];

	uwbe_conv u_conv (
		.clk(clk),
		.rst(rst),
		.cif(cif.cv)
	);

	// chip timing: sync, delimiter, then coded symbols
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= uwbe_pkg::ST_IDLE;
			c_r <= 13'h0000;
			nc_r <= uwbe_pkg::NC_850K;
			nb_r <= uwbe_pkg::NB_850K;
			sp_r <= 7'h00;
			k_r <= 5'h00;
			ns_r <= 5'h00;
			hdr_sym_r <= 1'b0;
		end else begin
			unique case (st_r)
				uwbe_pkg::ST_IDLE: begin
					if (go) begin
						st_r <= uwbe_pkg::ST_SYNC;
						sp_r <= 7'h00;
						k_r <= 5'h00;
						ns_r <= 5'h00;
					end
				end
				uwbe_pkg::ST_SYNC, uwbe_pkg::ST_SFD: begin
					sp_r <= sp_r + 7'h01;
					if (sp_r == spread_last) begin
						sp_r <= 7'h00;
						k_r <= k_r + 5'h01;
						if (k_r == uwbe_pkg::CODE_LAST) begin
							k_r <= 5'h00;
							ns_r <= ns_r + 5'h01;
							if (st_r == uwbe_pkg::ST_SYNC
								&& ns_r == uwbe_pkg::SYNC_LAST) begin
								st_r <= uwbe_pkg::ST_SFD;
								ns_r <= 5'h00;
							end
						end
					end
					if (pop) begin
						st_r <= uwbe_pkg::ST_SYM;
						c_r <= 13'h0000;
						nc_r <= uwbe_pkg::nc_of(sym_rate);
						nb_r <= uwbe_pkg::nb_of(sym_rate);
						hdr_sym_r <= qt_r[0];
					end else if (sym_end) begin
						st_r <= uwbe_pkg::ST_END;
					end
				end
				uwbe_pkg::ST_SYM: begin
					if (pop) begin
						c_r <= 13'h0000;
						nc_r <= uwbe_pkg::nc_of(sym_rate);
						nb_r <= uwbe_pkg::nb_of(sym_rate);
						hdr_sym_r <= qt_r[0];
					end else if (sym_end) begin
						st_r <= uwbe_pkg::ST_END;
					end else begin
						c_r <= c_r + 13'h0001;
					end
				end
				uwbe_pkg::ST_END: st_r <= uwbe_pkg::ST_IDLE;
				default: st_r <= uwbe_pkg::ST_IDLE;
			endcase
		end
	end

	// burst window: first burst slot of the chosen half
	assign lo = cif.pos ? (nc_r >> 1) : 13'h0000;
	assign sym_on = c_r >= lo && c_r < lo + {5'h00, nb_r};
	// preamble chip: code chip on first spread slot, delimiter sign applied
	assign pre_on = sp_r == 7'h00
		&& (codesel_r ? CODE_B_ON[k_r] : CODE_A_ON[k_r])
		&& (st_r == uwbe_pkg::ST_SYNC || uwbe_pkg::SFD_ON[ns_r[2:0]]);
	assign pre_neg = (codesel_r ? CODE_B_NEG[k_r] : CODE_A_NEG[k_r])
		^ (st_r == uwbe_pkg::ST_SFD && uwbe_pkg::SFD_NEG[ns_r[2:0]]);

	// registered outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_busy_r <= 1'b0;
			chip_on_r <= 1'b0;
			chip_neg_r <= 1'b0;
			sym_start_r <= 1'b0;
			sym_pos_r <= 1'b0;
			sym_pol_r <= 1'b0;
			sym_hdr_r <= 1'b0;
			frame_done_r <= 1'b0;
		end else begin
			tx_busy_r <= st_r != uwbe_pkg::ST_IDLE;
			if (st_r == uwbe_pkg::ST_SYNC || st_r == uwbe_pkg::ST_SFD) begin
				chip_on_r <= pre_on;
				chip_neg_r <= pre_on && pre_neg;
			end else begin
				chip_on_r <= st_r == uwbe_pkg::ST_SYM && sym_on;
				chip_neg_r <= st_r == uwbe_pkg::ST_SYM && sym_on && cif.pol;
			end
			sym_start_r <= st_r == uwbe_pkg::ST_SYM && c_r == 13'h0000;
			if (st_r == uwbe_pkg::ST_SYM && c_r == 13'h0000) begin
				sym_pos_r <= cif.pos;
				sym_pol_r <= cif.pol;
				sym_hdr_r <= hdr_sym_r;
			end
			frame_done_r <= st_r == uwbe_pkg::ST_END;
		end
	end

	assign tx_busy = tx_busy_r;
	assign chip_on = chip_on_r;
	assign chip_neg = chip_neg_r;
	assign sym_start = sym_start_r;
	assign sym_pos = sym_pos_r;
	assign sym_pol = sym_pol_r;
	assign sym_hdr = sym_hdr_r;
	assign frame_done = frame_done_r;

	// history for the checks below
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			popped_r <= 2'h0;
			sfd_seen_r <= 1'b0;
		end else begin
			if (pop) popped_r <= pop2 ? q_r : {q_r[0], popped_r[1]};
			if (go) sfd_seen_r <= 1'b0;
			else if (st_r == uwbe_pkg::ST_SFD && sym_end) sfd_seen_r <= 1'b1;
		end
	end

	a_hdr_count: assert property (@(posedge clk) disable iff (rst)
		src_r == uwbe_pkg::SRC_INFO |-> hb_r == uwbe_pkg::HDR_COUNT)
		else $error("payload started before 19 header bits");
	a_tail_zero: assert property (@(posedge clk) disable iff (rst)
		st_r == uwbe_pkg::ST_END |-> popped_r == 2'h0)
		else $error("frame did not end on zero tail bits");
	a_pay_lsb: assert property (@(posedge clk) disable iff (rst)
		push && src_r == uwbe_pkg::SRC_INFO && byte_r == 7'h00
		&& bit_r == 3'h0 ##1 qn_r != 2'h0 |-> q_r[qn_r[0] ^ 1'b1]
		== pay_mem_r[0][0])
		else $error("payload not sent lsb of first octet first");
	a_hdr_rate: assert property (@(posedge clk) disable iff (rst)
		st_r == uwbe_pkg::ST_SYM && hdr_sym_r |-> nc_r
		== (rate_r == uwbe_pkg::RATE_110K ? uwbe_pkg::NC_110K
		: uwbe_pkg::NC_850K))
		else $error("header symbol at wrong rate");
	a_data_rate: assert property (@(posedge clk) disable iff (rst)
		st_r == uwbe_pkg::ST_SYM && !hdr_sym_r |-> nc_r
		== uwbe_pkg::nc_of(rate_r))
		else $error("payload symbol at wrong rate");
	a_burst_slot: assert property (@(posedge clk) disable iff (rst)
		st_r == uwbe_pkg::ST_SYM && sym_on |-> c_r - lo < (nc_r >> 2))
		else $error("burst outside first half of interval");
	a_sync_first: assert property (@(posedge clk) disable iff (rst)
		st_r == uwbe_pkg::ST_SYM |-> sfd_seen_r)
		else $error("symbol sent before sync and delimiter");
	c_hdr_to_data: cover property (@(posedge clk) disable iff (rst)
		sym_start_r && sym_hdr_r ##[1:600] sym_start_r && !sym_hdr_r);
	c_frame_done: cover property (@(posedge clk) disable iff (rst)
		frame_done_r);
	c_slow_prf: cover property (@(posedge clk) disable iff (rst)
		slow_r && st_r == uwbe_pkg::ST_SFD);
endmodule // uwbe_encoder

// [uwbe_mac_model.sv]
// mac side: loads the payload store, then asks for a frame
module uwbe_mac_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command from the bench, busy from the encoder
	input wire logic go,
	input wire logic [6:0] len,
	input wire logic tx_busy,
	// encoder request and payload store
	output logic start,
	output logic pay_wr,
	output logic [6:0] pay_idx,
	output logic [7:0] pay_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [128];
	logic [7:0] cnt;
	logic act;
	logic [7:0] d;

	// octets one per cycle, then start held until busy is seen
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			start <= 1'b0;
			pay_wr <= 1'b0;
			pay_idx <= 7'h00;
			pay_data <= 8'h00;
			act <= 1'b0;
			cnt <= 8'h00;
		end else if (go && !act) begin
			act <= 1'b1;
			cnt <= 8'h00;
		end else if (act && cnt < {1'b0, len}) begin
			d = 8'($urandom);
			mem[cnt] = d;
			pay_wr <= 1'b1;
			pay_idx <= cnt[6:0];
			pay_data <= d;
			cnt <= cnt + 8'h01;
		end else if (act) begin
			// store untouched until the next go, so it stays stable
			pay_wr <= 1'b0;
			start <= !tx_busy;
			if (tx_busy) act <= 1'b0;
		end
	end
endmodule // uwbe_mac_model

// [uwb_phy_frame_symbol_encoder_test.sv]
// bench: random frames, symbol and chip stream checked per frame
module uwb_phy_frame_symbol_encoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [30:0] CA = 31'h1b2c3d4e; // arbitrary code masks
	localparam logic [30:0] CB = 31'h2e5a1c77;
	localparam int LIMIT = 95000;
	logic clk, rst, go, conv_bypass, code_sel, prf_slow, ranging;
	logic start, pay_wr, tx_busy, chip_on, chip_neg;
	logic sym_start, sym_pos, sym_pol, sym_hdr, frame_done, cp, ch, fin, cq;
	logic [1:0] pre_dur;
	logic [6:0] len, pay_idx;
	logic [7:0] pay_data;
	uwbe_pkg::uwbe_rate_type rate;
	logic pos_q [$];
	logic pol_q [$];
	logic hdr_q [$];
	int err_count, n_compared, tick, ns, cyc, ons, negs, first;
	int pre_cyc, pre_on, fd_n;
	int nct [4] = '{uwbe_pkg::NC_110K, uwbe_pkg::NC_850K,
		uwbe_pkg::NC_6M8, uwbe_pkg::NC_27M};
	int nbt [4] = '{uwbe_pkg::NB_110K, uwbe_pkg::NB_850K,
		uwbe_pkg::NB_6M8, uwbe_pkg::NB_27M};

	uwbe_encoder #(.CODE_A_ON(CA), .CODE_A_NEG(31'h01020304),
		.CODE_B_ON(CB), .CODE_B_NEG(31'h10203040)) uut (.clk(clk),
		.rst(rst), .start(start), .rate(rate), .conv_bypass(conv_bypass),
		.code_sel(code_sel), .prf_slow(prf_slow), .ranging(ranging),
		.pre_dur(pre_dur), .pay_len(len), .pay_wr(pay_wr),
		.pay_idx(pay_idx), .pay_data(pay_data), .tx_busy(tx_busy),
		.chip_on(chip_on), .chip_neg(chip_neg), .sym_start(sym_start),
		.sym_pos(sym_pos), .sym_pol(sym_pol), .sym_hdr(sym_hdr),
		.frame_done(frame_done));
	uwbe_mac_model mac (.clk(clk), .rst(rst), .go(go), .len(len),
		.tx_busy(tx_busy), .start(start), .pay_wr(pay_wr),
		.pay_idx(pay_idx), .pay_data(pay_data));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare one value, count it, report a miss
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (err_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// judge the burst of the symbol just ended
	task automatic close_sym(input bit full);
		int r;
		int nc;
		r = (ch && rate != uwbe_pkg::RATE_110K) ? 1 : int'(rate);
		nc = nct[r];
		if (full) chk("sym_len", cyc, nc);
		chk("burst_chips", ons, nbt[r]);
		chk("burst_half", first / (nc / 2), {31'h0, cp});
		chk("burst_quarter", (first % (nc / 2)) < nc / 4, 1);
		chk("burst_sign", negs == 0 || negs == ons, 1);
		chk("burst_pol", negs == ons && ons > 0, {31'h0, cq});
	endtask

	// watch the streams where they are settled
	always @(negedge clk) begin
		if (go) begin
			ns = 0; pre_cyc = 0; pre_on = 0; fd_n = 0; fin = 1'b0;
			pos_q.delete(); pol_q.delete(); hdr_q.delete();
		end else if (!rst && tx_busy && !fin) begin
			if (sym_start) begin
				if (ns > 0) close_sym(1);
				ns++; cyc = 0; ons = 0; negs = 0; first = -1;
				cp = sym_pos; ch = sym_hdr; cq = sym_pol;
				pos_q.push_back(sym_pos); pol_q.push_back(sym_pol);
				hdr_q.push_back(sym_hdr);
			end
			if (ns == 0) begin
				pre_cyc++;
				// count pulses over the whole sync part only
				if (chip_on && pre_cyc <= 7936 * (prf_slow ? 4 : 1)) pre_on++;
			end else begin
				if (chip_on && first < 0) first = cyc;
				if (chip_on) ons++;
				if (chip_on && chip_neg) negs++;
				cyc++;
			end
			if (frame_done) begin
				fd_n++; fin = 1'b1;
				if (ns > 0) close_sym(0);
			end
		end
	end

	// one frame: set fields, let the mac load and start, then judge
	task automatic frame(input uwbe_pkg::uwbe_rate_type r, input logic s,
		input logic [6:0] l);
		int m;
		int nd;
		logic [12:0] hb;
		@(posedge clk);
		rate <= r; prf_slow <= s; len <= l; go <= 1'b1;
		code_sel <= 1'($urandom); ranging <= 1'($urandom);
		pre_dur <= 2'($urandom);
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk iff frame_done);
		repeat (2) @(negedge clk);
		nd = (l == 0) ? 0 : l * 8 + 48;
		m = pos_q.size();
		hb = {pre_dur, 1'b0, ranging, l, rate};
		chk("done_pulses", fd_n, 1);
		chk("busy_end", tx_busy, 0);
		chk("sym_count", m, 21 + nd);
		chk("first_pos", pos_q[0], 0);
		chk("preamble", pre_cyc / (496 * (s ? 4 : 1)), 24);
		chk("sync_pulses", pre_on, 16 * $countones(code_sel ? CB : CA));
		for (int k = 0; k < m; k++) begin
			chk("hdr_flag", hdr_q[k], k < 19);
			chk("pol", pol_q[k], ((k + 1 < m) ? pos_q[k + 1] : 1'b0) ^
				((k > 0) ? pos_q[k - 1] : 1'b0));
		end
		for (int k = 0; k < 13; k++) chk("hdr_bit", pos_q[k + 1], hb[k]);
		for (int i = 0; i < l * 8; i++)
			chk("data_bit", pos_q[20 + i], mac.mem[i / 8][i % 8]);
		chk("tail", pos_q[m - 1], 0);
	endtask

	// hang guard
	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == LIMIT) begin
			err_count++;
			results();
		end
	end

	initial begin
		rst = 1'b1; go = 1'b0; rate = uwbe_pkg::RATE_110K; conv_bypass = 1'b0;
		code_sel = 1'b0; prf_slow = 1'b0; ranging = 1'b0; pre_dur = 2'h0;
		len = 7'h00; err_count = 0; n_compared = 0; tick = 0; fin = 1'b1;
		void'($urandom(61585));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		frame(uwbe_pkg::RATE_6M8, 1'b0, 7'(1 + $urandom % 3));
		frame(uwbe_pkg::RATE_27M, 1'b1, 7'h01);
		results();
	end
endmodule // uwb_phy_frame_symbol_encoder_test
